//--- hdl/sps_pkg.sv
package sps_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned PROG_TIME_MIN_NS = 3_700_000;
    localparam int unsigned PROG_TIME_MAX_NS = 4_500_000;
    localparam int unsigned PROG_CYCLES_DEF =
        (PROG_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PROG_CYCLES_MAX = PROG_TIME_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned PAGE_WORDS_DEF = 64;
    localparam int unsigned NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE_DEF = 112;
    localparam logic [2:0] SPM_WINDOW = 3'h4;
    localparam logic [2:0] LPM_WINDOW = 3'h3;
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_LOCKSET_BIT = 3;
    localparam int unsigned CTRL_BUSY_BIT = 6;
    localparam int unsigned CTRL_IRQEN_BIT = 7;
    localparam logic [6:0] CMD_LOAD = 7'h01;
    localparam logic [6:0] CMD_ERASE = 7'h03;
    localparam logic [6:0] CMD_WRITE = 7'h05;
    localparam logic [6:0] CMD_LOCK = 7'h09;
    localparam logic [6:0] CMD_REEN = 7'h11;
    localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
    localparam logic [15:0] Z_LOCK = 16'h0001;
    localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
    localparam logic [7:0] LPM_NORMAL_DATA = 8'hFF;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [1:0] LOCK_TOP = 2'h3;
    localparam logic [5:0] LOCK_RESET = 6'h3F;
    localparam logic [11:0] REG_CTRL_VAL = 12'h000;
    localparam logic [11:0] REG_ZPTR = 12'h004;
    localparam logic [11:0] REG_DATA = 12'h008;
    localparam logic [11:0] REG_ACTION = 12'h00C;
    localparam logic [11:0] REG_STATUS = 12'h010;
    localparam logic [11:0] REG_LPM_RESULT = 12'h014;
    localparam int unsigned ACT_CTRL_BIT = 0;
    localparam int unsigned ACT_SPM_BIT = 1;
    localparam int unsigned ACT_LPM_BIT = 2;
    localparam int unsigned ST_REFUSED_BIT = 5;
    localparam int unsigned ST_ORDER_BIT = 6;
    localparam int unsigned ST_REUSE_BIT = 7;

    typedef enum logic [2:0] {
        SPS_K_NONE = 3'b000,
        SPS_K_LOAD = 3'b001,
        SPS_K_ERASE = 3'b010,
        SPS_K_WRITE = 3'b011,
        SPS_K_LOCK = 3'b100,
        SPS_K_REEN = 3'b101
    } sps_cmd_type;

    function automatic sps_cmd_type sps_cmd_kind(input logic [6:0] c);
        case (c)
            CMD_LOAD: return SPS_K_LOAD;
            CMD_ERASE: return SPS_K_ERASE;
            CMD_WRITE: return SPS_K_WRITE;
            CMD_LOCK: return SPS_K_LOCK;
            CMD_REEN: return SPS_K_REEN;
            default: return SPS_K_NONE;
        endcase
    endfunction : sps_cmd_kind
endpackage : sps_pkg

//--- hdl/sps_if.sv
interface sps_if;
    logic ctrl_wr;
    logic [7:0] ctrl_wdata;
    logic [7:0] ctrl_rdata;
    logic spm_req;
    logic lpm_req;
    logic [15:0] z_ptr;
    logic [15:0] data_word;
    logic eeprom_busy;
    logic lpm_valid;
    logic lpm_special;
    logic [7:0] lpm_data;
    logic cpu_halt;
    logic rww_blocked;
    logic spm_irq;

    modport device (
        input ctrl_wr, ctrl_wdata, spm_req, lpm_req, z_ptr, data_word,
        input eeprom_busy,
        output ctrl_rdata, lpm_valid, lpm_special, lpm_data, cpu_halt,
        output rww_blocked, spm_irq
    );
    modport host (
        output ctrl_wr, ctrl_wdata, spm_req, lpm_req, z_ptr, data_word,
        output eeprom_busy,
        input ctrl_rdata, lpm_valid, lpm_special, lpm_data, cpu_halt,
        input rww_blocked, spm_irq
    );
endinterface : sps_if

//--- hdl/sps_prog_timer.sv
module sps_prog_timer #(
    parameter int unsigned CYCLES = sps_pkg::PROG_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic start,
    output logic busy,
    output logic done
);
    import sps_pkg::*;
    localparam int unsigned CW = $clog2(CYCLES + 1);

    if (CYCLES < 1 || CYCLES > PROG_CYCLES_MAX) begin : g_bad_cycles
        $error("sps_prog_timer: CYCLES out of range");
    end

    logic [CW-1:0] count;

    // Start while running is ignored; the sequencer never overlaps ops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (start && count == '0) begin
            count <= CW'(CYCLES);
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            done <= 1'b0;
        end else begin
            done <= (count == CW'(1));
        end
    end

    assign busy = (count != '0);
endmodule : sps_prog_timer

//--- hdl/sps_device.sv
// Overview of operation
// [R1] Erase precedes write; buffer survives erase
// [R2] Erase and write address same page
// [R3] Erase command then store within four cycles
// [R4] Erase uses only the page index
// [R5] Own-section ops halt CPU, else readable
// [R6] Load puts data word at word index
// [R7] Buffer cleared: write done, re-enable, reset
// [R8] Each buffer slot loaded once per clear
// [R9] EEPROM write during loading discards buffer
// [R10] Write command then store within four
// [R11] Interrupt held while enable bit clear
// [R12] Erase/write block section, busy flag set
// [R13] Re-enable write clears the busy flag
// [R14] Lock command then store within four
// [R15] Zero data bits program lock bits
// [R16] EEPROM busy refuses commands and reads
// [R17] Software checks EEPROM busy before commands
// [R18] Lock read at pointer one, three cycles
// [R19] Enable and lock-set clear on finish/timeout
// [R20] Pointers zero, three, two read fuses
// [R21] Programmed bits read zero, unprogrammed one
// [R22] Lock writes use pointer one, top ones
// [R23] Long operations take 3.7 to 4.5 ms
// [R24] Enable stays set until operation ends
//
// Decided for this implementation: the APB slave port and the register addresses.
module sps_device #(
    parameter int unsigned PROG_CYCLES = sps_pkg::PROG_CYCLES_DEF,
    parameter int unsigned PAGE_WORDS = sps_pkg::PAGE_WORDS_DEF,
    parameter int unsigned NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = sps_pkg::NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    sps_if.device link,
    input wire logic [7:0] fuse_low_prog,
    input wire logic [7:0] fuse_high_prog,
    input wire logic [7:0] fuse_ext_prog,
    input wire logic [$clog2(PAGE_WORDS)-1:0] buf_rd_addr,
    output logic [15:0] buf_rd_data,
    output sps_pkg::sps_cmd_type flash_op,
    output logic [14-$clog2(PAGE_WORDS):0] flash_page,
    output logic flash_op_done,
    output logic [5:0] lock_bits
);
    import sps_pkg::*;
    localparam int unsigned WB = $clog2(PAGE_WORDS);
    localparam int unsigned PB = 15 - WB;

    if (PAGE_WORDS < 2 || (1 << WB) != PAGE_WORDS || WB > 12
        || NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE >= (1 << PB)) begin : g_bad_geometry
        $error("sps_device: unsupported page geometry");
    end

    typedef enum logic [1:0] {
        SPS_D_IDLE = 2'b00,
        SPS_D_ARMED = 2'b01,
        SPS_D_BUSY = 2'b10
    } sps_dstate_type;

    sps_dstate_type state;
    logic [6:0] cmd;
    logic irq_en;
    logic rww_busy;
    logic [2:0] win_cnt;
    logic [15:0] buf_mem [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] buf_valid;
    logic [5:0] lock_data;
    logic eeprom_busy_d;
    logic timer_start;
    logic timer_busy;
    logic op_done;
    sps_cmd_type kind;
    logic ctrl_take;
    logic spm_go;
    logic lpm_go;
    logic timeout;
    logic long_op;
    logic [WB-1:0] z_word;
    logic [PB-1:0] z_page;
    logic [7:0] fuse_sel;

    assign kind = sps_cmd_kind(cmd);
    assign z_word = link.z_ptr[WB:1];
    assign z_page = link.z_ptr[15:WB+1];
    // Commands are refused outright while the EEPROM writes
    assign ctrl_take = link.ctrl_wr && state == SPS_D_IDLE
        && !link.eeprom_busy; // [R16]
    assign spm_go = state == SPS_D_ARMED && link.spm_req
        && !link.eeprom_busy; // [R3] [R6] [R10] [R14] [R16]
    assign lpm_go = state == SPS_D_ARMED && link.lpm_req
        && cmd[CTRL_LOCKSET_BIT] && !link.eeprom_busy
        && win_cnt > SPM_WINDOW - LPM_WINDOW; // [R18] [R16]
    assign timeout = state == SPS_D_ARMED && !spm_go && !lpm_go
        && win_cnt == 3'h1; // [R19]
    assign long_op = kind == SPS_K_ERASE || kind == SPS_K_WRITE
        || kind == SPS_K_LOCK;
    assign timer_start = spm_go && long_op;

    sps_prog_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .start(timer_start),
        .busy(timer_busy),
        .done(op_done)
    ); // [R23]

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= SPS_D_IDLE;
            win_cnt <= 3'h0;
        end else begin
            case (state)
                SPS_D_IDLE: begin
                    if (ctrl_take && link.ctrl_wdata[CTRL_EN_BIT]) begin
                        state <= SPS_D_ARMED;
                        win_cnt <= SPM_WINDOW; // [R3]
                    end
                end
                SPS_D_ARMED: begin
                    win_cnt <= win_cnt - 3'h1;
                    if (timer_start) begin
                        state <= SPS_D_BUSY;
                    end else if (spm_go || lpm_go || timeout) begin
                        state <= SPS_D_IDLE;
                    end
                end
                SPS_D_BUSY: begin
                    if (op_done) begin
                        state <= SPS_D_IDLE;
                    end
                end
                default: state <= SPS_D_IDLE;
            endcase
        end
    end

    // Command bits hold through the operation and clear at its end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmd <= 7'h00;
            irq_en <= 1'b0;
        end else if (ctrl_take) begin
            cmd <= link.ctrl_wdata[6:0];
            irq_en <= link.ctrl_wdata[CTRL_IRQEN_BIT];
        end else if ((spm_go && !long_op) || lpm_go || timeout) begin
            cmd <= 7'h00; // [R19]
        end else if (state == SPS_D_BUSY && op_done) begin
            cmd <= 7'h00; // [R24]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rww_busy <= 1'b0;
        end else if (timer_start && kind != SPS_K_LOCK
            && z_page < PB'(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)) begin
            rww_busy <= 1'b1; // [R12] [R5]
        end else if (spm_go && kind == SPS_K_REEN) begin
            rww_busy <= 1'b0; // [R13]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flash_op <= SPS_K_NONE;
            flash_page <= '0;
            lock_data <= LOCK_RESET;
        end else if (timer_start) begin
            flash_op <= kind;
            flash_page <= z_page; // [R4] [R2]
            lock_data <= link.data_word[5:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flash_op_done <= 1'b0;
        end else begin
            flash_op_done <= state == SPS_D_BUSY && op_done;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lock_bits <= LOCK_RESET;
        end else if (state == SPS_D_BUSY && op_done
            && flash_op == SPS_K_LOCK) begin
            lock_bits <= lock_bits & lock_data; // [R15]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            eeprom_busy_d <= 1'b0;
        end else begin
            eeprom_busy_d <= link.eeprom_busy;
        end
    end

    // Validity is kept per slot so a clear is one cycle, not a sweep;
    // erase does not touch the buffer, so it may be filled before it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            buf_valid <= '0; // [R7]
        end else if (state == SPS_D_BUSY && op_done
            && flash_op == SPS_K_WRITE) begin
            buf_valid <= '0; // [R7] [R1]
        end else if (spm_go && kind == SPS_K_REEN) begin
            buf_valid <= '0; // [R7]
        end else if (link.eeprom_busy && !eeprom_busy_d) begin
            buf_valid <= '0; // [R9]
        end else if (spm_go && kind == SPS_K_LOAD) begin
            buf_valid[z_word] <= 1'b1; // [R6]
        end
    end

    // A second load to one slot simply overwrites it
    always_ff @(posedge clk_sys) begin
        if (spm_go && kind == SPS_K_LOAD) begin
            buf_mem[z_word] <= link.data_word; // [R6]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            buf_rd_data <= ERASED_WORD;
        end else if (buf_valid[buf_rd_addr]) begin
            buf_rd_data <= buf_mem[buf_rd_addr];
        end else begin
            buf_rd_data <= ERASED_WORD;
        end
    end

    always_comb begin
        case (link.z_ptr)
            Z_FUSE_LOW: fuse_sel = ~fuse_low_prog; // [R20] [R21]
            Z_LOCK: fuse_sel = {LOCK_TOP, lock_bits}; // [R18] [R21]
            Z_FUSE_EXT: fuse_sel = ~fuse_ext_prog; // [R20]
            Z_FUSE_HIGH: fuse_sel = ~fuse_high_prog; // [R20]
            default: fuse_sel = LPM_NORMAL_DATA;
        endcase
    end

    // Every load-program is answered next cycle; special only in window
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            link.lpm_valid <= 1'b0;
            link.lpm_special <= 1'b0;
            link.lpm_data <= LPM_NORMAL_DATA;
        end else begin
            link.lpm_valid <= link.lpm_req;
            link.lpm_special <= lpm_go;
            link.lpm_data <= lpm_go ? fuse_sel : LPM_NORMAL_DATA; // [R19]
        end
    end

    assign link.ctrl_rdata = {irq_en, rww_busy, cmd[5:0]};
    assign link.cpu_halt = timer_busy && flash_op != SPS_K_LOCK
        && flash_page >= PB'(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE); // [R5] [R15]
    assign link.rww_blocked = rww_busy; // [R12]
    assign link.spm_irq = irq_en && !cmd[CTRL_EN_BIT]; // [R11]
endmodule : sps_device

//--- hdl/sps_host.sv
module sps_host #(
    parameter int unsigned PAGE_WORDS = sps_pkg::PAGE_WORDS_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    sps_if.host link,
    input wire logic eeprom_write_busy,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import sps_pkg::*;
    localparam int unsigned WB = $clog2(PAGE_WORDS);
    localparam int unsigned PB = 15 - WB;

    if (PAGE_WORDS < 2 || (1 << WB) != PAGE_WORDS || WB > 12) begin : g_bad
        $error("sps_host: unsupported page size");
    end

    typedef enum logic [1:0] {
        SPS_H_IDLE = 2'b00,
        SPS_H_CTRL = 2'b01,
        SPS_H_OP = 2'b10
    } sps_hstate_type;

    sps_hstate_type state;
    logic [7:0] ctrl_val;
    logic [15:0] zptr;
    logic [15:0] data;
    logic [2:0] act;
    logic [7:0] lpm_result;
    logic lpm_was_special;
    logic refused;
    logic err_order;
    logic err_reuse;
    logic [PAGE_WORDS-1:0] slot_used;
    logic [PB-1:0] erased_page;
    logic erased_ok;
    logic wr_en;
    logic act_wr;
    logic launch;
    logic bad_order;
    logic bad_reuse;
    sps_cmd_type kind;

    // The CPU stalls while the flash holds it halted
    assign pready = !link.cpu_halt;
    assign wr_en = psel && penable && pready && pwrite;
    assign act_wr = wr_en && paddr == REG_ACTION && state == SPS_H_IDLE;
    assign kind = sps_cmd_kind(ctrl_val[6:0]);
    assign bad_order = pwdata[ACT_SPM_BIT] && kind == SPS_K_WRITE
        && (!erased_ok || erased_page != zptr[15:WB+1]); // [R1] [R2]
    assign bad_reuse = pwdata[ACT_SPM_BIT] && kind == SPS_K_LOAD
        && slot_used[zptr[WB:1]]; // [R8]
    assign launch = act_wr && !eeprom_write_busy
        && !bad_order && !bad_reuse; // [R17]

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_val <= 8'h00;
            zptr <= 16'h0000;
            data <= 16'h0000;
            act <= 3'h0;
        end else if (wr_en && state == SPS_H_IDLE) begin
            case (paddr)
                REG_CTRL_VAL: ctrl_val <= pwdata[7:0];
                REG_ZPTR: zptr <= pwdata[15:0];
                REG_DATA: data <= pwdata[15:0];
                REG_ACTION: act <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            link.z_ptr <= 16'h0000;
            link.data_word <= 16'h0000;
            link.ctrl_wdata <= 8'h00;
        end else if (launch) begin
            link.ctrl_wdata <= ctrl_val;
            link.data_word <= data;
            link.z_ptr <= zptr;
            if (kind == SPS_K_LOCK && pwdata[ACT_SPM_BIT]) begin
                link.z_ptr <= Z_LOCK; // [R22]
                link.data_word <= {data[15:8], LOCK_TOP, data[5:0]}; // [R22]
            end else if (kind == SPS_K_WRITE) begin
                link.z_ptr <= {zptr[15:WB+1], (WB + 1)'(0)}; // [R10]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= SPS_H_IDLE;
        end else begin
            case (state)
                SPS_H_IDLE: begin
                    if (launch && pwdata[ACT_CTRL_BIT]) begin
                        state <= SPS_H_CTRL;
                    end else if (launch && pwdata[2:1] != 2'h0) begin
                        state <= SPS_H_OP;
                    end
                end
                SPS_H_CTRL: begin
                    state <= act[2:1] != 2'h0 ? SPS_H_OP : SPS_H_IDLE;
                end
                SPS_H_OP: state <= SPS_H_IDLE;
                default: state <= SPS_H_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            slot_used <= '0;
            erased_ok <= 1'b0;
            erased_page <= '0;
        end else if (state == SPS_H_OP && act[ACT_SPM_BIT]) begin
            case (kind)
                SPS_K_ERASE: begin
                    erased_ok <= 1'b1;
                    erased_page <= link.z_ptr[15:WB+1];
                end
                SPS_K_WRITE: begin
                    erased_ok <= 1'b0;
                    slot_used <= '0;
                end
                SPS_K_REEN: slot_used <= '0;
                SPS_K_LOAD: slot_used[link.z_ptr[WB:1]] <= 1'b1;
                default: ;
            endcase
        end
    end

    // Sticky flags: a new event wins over a write-one clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            refused <= 1'b0;
            err_order <= 1'b0;
            err_reuse <= 1'b0;
        end else begin
            if (wr_en && paddr == REG_STATUS) begin
                refused <= refused && !pwdata[ST_REFUSED_BIT];
                err_order <= err_order && !pwdata[ST_ORDER_BIT];
                err_reuse <= err_reuse && !pwdata[ST_REUSE_BIT];
            end
            if (act_wr && eeprom_write_busy) begin
                refused <= 1'b1;
            end
            if (act_wr && bad_order) begin
                err_order <= 1'b1;
            end
            if (act_wr && bad_reuse) begin
                err_reuse <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lpm_result <= 8'h00;
            lpm_was_special <= 1'b0;
        end else if (link.lpm_valid) begin
            lpm_result <= link.lpm_data;
            lpm_was_special <= link.lpm_special;
        end
    end

    always_comb begin
        case (paddr)
            REG_CTRL_VAL: prdata = {24'h000000, ctrl_val};
            REG_ZPTR: prdata = {16'h0000, zptr};
            REG_DATA: prdata = {16'h0000, data};
            REG_ACTION: prdata = {29'h00000000, act};
            REG_STATUS: prdata = {16'h0000, link.ctrl_rdata, err_reuse,
                err_order, refused, lpm_was_special, link.spm_irq,
                link.rww_blocked, eeprom_write_busy, state != SPS_H_IDLE};
            REG_LPM_RESULT: prdata = {24'h000000, lpm_result};
            default: prdata = 32'h00000000;
        endcase
    end

    assign pslverr = psel && penable && paddr != REG_CTRL_VAL
        && paddr != REG_ZPTR && paddr != REG_DATA && paddr != REG_ACTION
        && paddr != REG_STATUS && paddr != REG_LPM_RESULT;
    assign link.ctrl_wr = state == SPS_H_CTRL;
    assign link.spm_req = state == SPS_H_OP && act[ACT_SPM_BIT];
    assign link.lpm_req = state == SPS_H_OP && !act[ACT_SPM_BIT]
        && act[ACT_LPM_BIT];
    assign link.eeprom_busy = eeprom_write_busy;
endmodule : sps_host

//--- tb/sps_checker.sv
module sps_checker #(
    parameter int PROG_CYCLES = 20
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic [7:0] ctrl_rdata,
    input wire logic spm_req,
    input wire logic lpm_req,
    input wire logic [15:0] z_ptr,
    input wire logic eeprom_busy,
    input wire logic lpm_valid,
    input wire logic lpm_special,
    input wire logic [7:0] lpm_data,
    input wire logic cpu_halt,
    input wire logic rww_blocked,
    input wire logic spm_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic long_op, page_op;
    assign long_op = spm_req && ctrl_rdata[5:0] inside {6'h03, 6'h05, 6'h09};
    assign page_op = spm_req && ctrl_rdata[5:0] inside {6'h03, 6'h05};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    AST_OP_TIME: assert property (long_op |-> ##PROG_CYCLES
        ctrl_rdata[0][*2] ##1 !ctrl_rdata[0]) else $error("op time");
    AST_RWW_BUSY: assert property (page_op && z_ptr[15:7] < 9'h070
        |=> ctrl_rdata[6] && rww_blocked) else $error("section not blocked");
    AST_HALT: assert property (page_op
        |=> cpu_halt == ($past(z_ptr[15:7]) >= 9'h070)) else $error("halt");
    AST_HALT_EN: assert property (cpu_halt |-> ctrl_rdata[0])
        else $error("halt without enable");
    AST_REEN: assert property (spm_req && ctrl_rdata[5:0] == 6'h11
        |=> !ctrl_rdata[6]) else $error("busy flag kept");
    AST_IRQ: assert property (spm_irq ==
        (ctrl_rdata[7] && !ctrl_rdata[0])) else $error("irq level wrong");
    AST_LPM_ANS: assert property (lpm_req |=> lpm_valid)
        else $error("no read answer");
    AST_LPM_NORM: assert property (lpm_valid && !lpm_special
        |-> lpm_data == 8'hFF) else $error("normal read data");
    AST_EE_LPM: assert property (eeprom_busy && lpm_req
        |=> !lpm_special) else $error("special read while busy");
    AST_ARM: assert property (ctrl_wr && ctrl_wdata[0]
        && !ctrl_rdata[0] && !eeprom_busy |=> ctrl_rdata[5:0] ==
        $past(ctrl_wdata[5:0])) else $error("not armed");
    AST_WIN: assert property ($rose(ctrl_rdata[0])
        ##0 (!spm_req && !lpm_req)[*6] |-> !ctrl_rdata[0])
        else $error("window kept open");
endmodule : sps_checker

//--- tb/testbench.sv
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    error_cnt++; $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sps_pkg::*;
    localparam logic [7:0] FL = 8'h5A, FH = 8'h3C, FE = 8'h07;
    logic clk_sys = 0, rst_b = 0, ee = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, err, done;
    logic [5:0] ba = '0, lb;
    logic [15:0] bd;
    logic [8:0] fpg;
    sps_cmd_type fop;
    int error_cnt = 0, samples_checked = 0, n_done = 0;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) n_done += int'(done === 1'b1);
    sps_if link();
    sps_device #(.PROG_CYCLES(20)) i_sps_device (.clk_sys(clk_sys),
        .rst_b(rst_b), .link(link), .fuse_low_prog(FL), .fuse_high_prog(FH),
        .fuse_ext_prog(FE), .buf_rd_addr(ba), .buf_rd_data(bd),
        .flash_op(fop), .flash_page(fpg), .flash_op_done(done), .lock_bits(lb));
    sps_host i_sps_host (.clk_sys(clk_sys), .rst_b(rst_b), .link(link),
        .eeprom_write_busy(ee), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    sps_checker #(.PROG_CYCLES(20)) i_sps_checker (.clk_sys(clk_sys),
        .rst_b(rst_b), .ctrl_wr(link.ctrl_wr), .ctrl_wdata(link.ctrl_wdata),
        .ctrl_rdata(link.ctrl_rdata), .spm_req(link.spm_req),
        .lpm_req(link.lpm_req), .z_ptr(link.z_ptr),
        .eeprom_busy(link.eeprom_busy), .lpm_valid(link.lpm_valid),
        .lpm_special(link.lpm_special), .lpm_data(link.lpm_data),
        .cpu_halt(link.cpu_halt), .rww_blocked(link.rww_blocked),
        .spm_irq(link.spm_irq));
    task automatic tally_and_finish();
        $display("mismatches %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    // Idle cycle after each transfer keeps psel single-driven per step
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 200);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 200) begin
            error_cnt++;
            tally_and_finish();
        end
        @(posedge clk_sys);
    endtask : apb
    task automatic op(input logic [7:0] c, input logic [15:0] z,
        input logic [15:0] d, input logic [2:0] act);
        int n;
        apb(1'b1, REG_CTRL_VAL, {24'h0, c});
        apb(1'b1, REG_ZPTR, {16'h0, z});
        apb(1'b1, REG_DATA, {16'h0, d});
        apb(1'b1, REG_ACTION, {29'h0, act});
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while ((r[0] | r[8]) !== 1'b0 && n < 100);
        if (n >= 100) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask : op
    task automatic peek(input logic [5:0] s, input logic [15:0] e);
        ba <= s;
        repeat (3) @(posedge clk_sys);
        `CHK(bd, e)
    endtask : peek
    task automatic t_prog();
        op(8'h01, 16'h018A, 16'h1234, 3'h3);
        peek(6'h05, 16'h1234);
        peek(6'h06, ERASED_WORD);
        op(8'h83, 16'h01BE, 16'hDEAD, 3'h3);
        `CHK(fop, SPS_K_ERASE)
        `CHK(fpg, 9'h003)
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK(r[14], 1'b1)
        `CHK(r[3], 1'b1)
        peek(6'h05, 16'h1234);
        op(8'h05, 16'h0180, 16'h0, 3'h3);
        `CHK(fop, SPS_K_WRITE)
        `CHK(fpg, 9'h003)
        peek(6'h05, ERASED_WORD);
        op(8'h11, 16'h0, 16'h0, 3'h3);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK(r[14], 1'b0)
        op(8'h03, 16'h3800, 16'h0, 3'h3);
        `CHK(fpg, 9'h070)
        `CHK(n_done, 3)
    endtask : t_prog
    task automatic t_lock();
        logic [15:0] zs [3] = '{Z_FUSE_LOW, Z_FUSE_HIGH, Z_FUSE_EXT};
        logic [7:0] fs [3] = '{FL, FH, FE};
        op(8'h09, Z_LOCK, 16'h00F2, 3'h3);
        `CHK(lb, 6'h32)
        op(8'h09, Z_LOCK, 16'h0, 3'h5);
        apb(1'b0, REG_LPM_RESULT, 32'h0);
        `CHK(r[5:0], 6'h32)
        for (int i = 0; i < 3; i++) begin
            op(8'h09, zs[i], 16'h0, 3'h5);
            apb(1'b0, REG_LPM_RESULT, 32'h0);
            `CHK(r[7:0], ~fs[i])
        end
        op(8'h09, Z_LOCK, 16'h0, 3'h1);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK(r[11:8], 4'h0)
    endtask : t_lock
    task automatic t_ee();
        op(8'h01, 16'h0004, 16'hBEEF, 3'h3);
        apb(1'b1, REG_CTRL_VAL, 32'h9);
        apb(1'b1, REG_ZPTR, {16'h0, Z_FUSE_LOW});
        apb(1'b1, REG_ACTION, 32'h5);
        ee <= 1'b1;
        peek(6'h02, ERASED_WORD);
        apb(1'b0, REG_LPM_RESULT, 32'h0);
        `CHK(r[7:0], LPM_NORMAL_DATA)
        op(8'h03, 16'h0180, 16'h0, 3'h3);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK(r[5], 1'b1)
        ee <= 1'b0;
        apb(1'b0, 12'hFF0, 32'h0);
        `CHK(err, 1'b1)
    endtask : t_ee
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        `CHK(lb, LOCK_RESET)
        t_prog();
        t_lock();
        t_ee();
        tally_and_finish();
    end
endmodule : testbench
